// [rtl/sarc_pkg.sv]
/*
  Package for the successive-approximation converter control block:
  register offsets, field positions, reset values and timing counts.
  Assumes an 8-bit register port with a 4-bit address.
*/
`default_nettype none
package sarc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS_CONTROL_ONE     = 4'h0;
  localparam logic [3:0] OFS_STATUS_CONTROL_TWO     = 4'h1;
  localparam logic [3:0] OFS_RESULT_HIGH            = 4'h2;
  localparam logic [3:0] OFS_RESULT_LOW             = 4'h3;
  localparam logic [3:0] OFS_COMPARE_HIGH           = 4'h4;
  localparam logic [3:0] OFS_COMPARE_LOW            = 4'h5;
  localparam logic [3:0] OFS_CONFIG                 = 4'h6;
  localparam logic [3:0] OFS_ANALOG_PIN_DISABLE_MID  = 4'h7;
  localparam logic [3:0] OFS_ANALOG_PIN_DISABLE_HIGH = 4'h8;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_CONVERSION_COMPLETE_FLAG     = 7;   // Status one: conversion complete
  localparam int POS_COMPLETION_INTERRUPT_ENABLE     = 6;   // Status one: completion interrupt enable
  localparam int POS_CONT     = 5;   // Status one: continuous conversion
  localparam int POS_CH_LSB   = 0;   // Status one: channel select, 5 bits
  localparam int POS_ACTIVE   = 7;   // Status two: conversion in progress
  localparam int POS_HWT_EN   = 6;   // Status two: hardware trigger enable
  localparam int POS_CMP_EN   = 5;   // Status two: compare enable
  localparam int POS_CMP_GT   = 4;   // Status two: compare greater-or-equal
  localparam int POS_DIV_LSB  = 5;   // Config: divide field, 2 bits
  localparam int POS_MODE_LSB = 2;   // Config: conversion mode, 2 bits
  localparam int POS_SRC_LSB  = 0;   // Config: clock source, 2 bits
  // ----------------------------------------------------------------
  // Field encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_12BIT = 2'h1;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] SRC_BUS      = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT      = 2'h2;
  localparam logic [1:0] SRC_ASYNC    = 2'h3;
  localparam logic [4:0] CH_OFF       = 5'h1F;
  localparam logic [7:0] RST_STATUS_ONE = 8'h1F;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int SAMPLE_TICKS   = 4;  // Converter clock ticks of sampling
  localparam int ASYNC_OSC_DIV  = 5;  // System cycles per internal oscillator tick
endpackage
`default_nettype wire

// [rtl/sarc_top.sv]
/*
  Digital control of a 12-bit successive-approximation converter:
  register port, pin disables, converter clock, trigger, SAR sequencing,
  rounding, compare and completion flag.
  Assumes an analogue comparator outside that answers dac_code_out,
  and pins or oscillators outside the clk_sys domain on the *_in pins.
*/
`timescale 1ns/1ps
`default_nettype none
module sarc_top #(
  parameter int SAMPLE_TICKS  = sarc_pkg::SAMPLE_TICKS,
  parameter int ASYNC_OSC_DIV = sarc_pkg::ASYNC_OSC_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        hardware_trigger_input,
  input  wire logic        alternate_clock,
  input  wire logic        sleep_mode_in,
  input  wire logic        comparator_in,
  input  wire logic [15:0] pin_level_in,
  output var  logic [11:0] dac_code_out,
  output var  logic [4:0]  channel_out,
  output var  logic        converter_active_out,
  output var  logic        converter_clock_tick_out,
  output var  logic        async_osc_on_out,
  output var  logic [15:0] pin_hiz_out,
  output var  logic [15:0] pin_pullup_off_out,
  output var  logic [15:0] pin_input_off_out,
  output var  logic [15:0] port_read_out,
  output var  logic        irq_out
);
  initial begin
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 32 || ASYNC_OSC_DIV < 1 || ASYNC_OSC_DIV > 255) begin
      $error("sarc_top: parameter out of range");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SAMPLE  = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DONE    = 4'b1000
  } sarc_state_type;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  ctl1_reg, ctl2_reg, cfg_reg, cvh_reg, cvl_reg;
  logic [7:0]  res_high_reg, res_low_reg;
  logic [7:0]  analog_pin_disable_mid, analog_pin_disable_high;
  logic        conversion_complete_flag_reg;
  logic [11:0] sar_reg;
  logic [3:0]  bit_idx_reg;
  logic [4:0]  samp_cnt_reg;
  sarc_state_type state_reg, state_next;

  // Address decode as named strobes
  wire wr_ctl1  = reg_wr && reg_addr == sarc_pkg::OFS_STATUS_CONTROL_ONE;
  wire wr_ctl2  = reg_wr && reg_addr == sarc_pkg::OFS_STATUS_CONTROL_TWO;
  wire wr_cfg   = reg_wr && reg_addr == sarc_pkg::OFS_CONFIG;
  wire wr_cvh   = reg_wr && reg_addr == sarc_pkg::OFS_COMPARE_HIGH;
  wire wr_cvl   = reg_wr && reg_addr == sarc_pkg::OFS_COMPARE_LOW;
  wire wr_mid   = reg_wr && reg_addr == sarc_pkg::OFS_ANALOG_PIN_DISABLE_MID;
  wire wr_high  = reg_wr && reg_addr == sarc_pkg::OFS_ANALOG_PIN_DISABLE_HIGH;
  wire rd_low   = reg_rd && reg_addr == sarc_pkg::OFS_RESULT_LOW;
  // A mode change invalidates any conversion under way
  wire mode_wr  = wr_ctl2 || wr_cfg || wr_cvh || wr_cvl;

  wire [4:0] chan_sel  = ctl1_reg[sarc_pkg::POS_CH_LSB +: 5];
  wire       cont_en   = ctl1_reg[sarc_pkg::POS_CONT];
  wire       completion_interrupt_enable      = ctl1_reg[sarc_pkg::POS_COMPLETION_INTERRUPT_ENABLE];
  wire       hwt_en    = ctl2_reg[sarc_pkg::POS_HWT_EN];
  wire       cmp_en    = ctl2_reg[sarc_pkg::POS_CMP_EN];
  wire       cmp_gt    = ctl2_reg[sarc_pkg::POS_CMP_GT];
  wire [1:0] div_sel   = cfg_reg[sarc_pkg::POS_DIV_LSB +: 2];
  wire [1:0] mode_sel  = cfg_reg[sarc_pkg::POS_MODE_LSB +: 2];
  wire [1:0] src_sel   = cfg_reg[sarc_pkg::POS_SRC_LSB +: 2];
  wire       wr_ch_off = reg_wdata[sarc_pkg::POS_CH_LSB +: 5] == sarc_pkg::CH_OFF;

  // Control registers; the flag of status one and the active and reserved bits of status two never store
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctl1_reg                <= sarc_pkg::RST_STATUS_ONE;
      ctl2_reg                <= sarc_pkg::RST_ZERO;
      cfg_reg                 <= sarc_pkg::RST_ZERO;
      cvh_reg                 <= sarc_pkg::RST_ZERO;
      cvl_reg                 <= sarc_pkg::RST_ZERO;
      analog_pin_disable_mid  <= sarc_pkg::RST_ZERO;
      analog_pin_disable_high <= sarc_pkg::RST_ZERO;
    end else begin
      if (wr_ctl1) ctl1_reg <= {1'b0, reg_wdata[6:0]};
      if (wr_ctl2) ctl2_reg <= {1'b0, reg_wdata[6:4], 4'h0};
      if (wr_cfg)  cfg_reg <= reg_wdata;
      if (wr_cvh)  cvh_reg <= reg_wdata;
      if (wr_cvl)  cvl_reg <= reg_wdata;
      if (wr_mid)  analog_pin_disable_mid <= reg_wdata;
      if (wr_high) analog_pin_disable_high <= reg_wdata;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      sarc_pkg::OFS_STATUS_CONTROL_ONE:      rd_mux = {conversion_complete_flag_reg, ctl1_reg[6:0]};
      sarc_pkg::OFS_STATUS_CONTROL_TWO:      rd_mux = {~state_reg[0], ctl2_reg[6:0]};
      sarc_pkg::OFS_RESULT_HIGH:             rd_mux = res_high_reg;
      sarc_pkg::OFS_RESULT_LOW:              rd_mux = res_low_reg;
      sarc_pkg::OFS_COMPARE_HIGH:            rd_mux = cvh_reg;
      sarc_pkg::OFS_COMPARE_LOW:             rd_mux = cvl_reg;
      sarc_pkg::OFS_CONFIG:                  rd_mux = cfg_reg;
      sarc_pkg::OFS_ANALOG_PIN_DISABLE_MID:  rd_mux = analog_pin_disable_mid;
      sarc_pkg::OFS_ANALOG_PIN_DISABLE_HIGH: rd_mux = analog_pin_disable_high;
      default:                               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) reg_rdata <= 8'h00;
    else reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // ----------------------------------------------------------------
  // Pin disables and synchronisers
  // ----------------------------------------------------------------
  logic [15:0] pin_s1, pin_s2, pin_dis_q;
  logic        trg_s1, trg_s2, trg_s3, alt_s1, alt_s2, alt_s3;
  wire  [15:0] dis_vec = {analog_pin_disable_high, analog_pin_disable_mid};

  // Pins and trigger come from outside the clock domain: two flops first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {pin_s1, pin_s2, pin_dis_q, port_read_out} <= 64'h0000_0000_0000_0000;
      {trg_s1, trg_s2, trg_s3, alt_s1, alt_s2, alt_s3} <= 6'h00;
    end else begin
      pin_s1        <= pin_level_in;
      pin_s2        <= pin_s1;
      pin_dis_q     <= dis_vec;
      port_read_out <= pin_s2 & ~dis_vec;
      trg_s1        <= hardware_trigger_input;
      trg_s2        <= trg_s1;
      trg_s3        <= trg_s2;
      alt_s1        <= alternate_clock;
      alt_s2        <= alt_s1;
      alt_s3        <= alt_s2;
    end
  end

  assign pin_hiz_out        = pin_dis_q;
  assign pin_pullup_off_out = pin_dis_q;
  assign pin_input_off_out  = pin_dis_q;

  wire trig_rise = trg_s2 && !trg_s3;
  wire alt_rise  = alt_s2 && !alt_s3;

  // ----------------------------------------------------------------
  // Converter clock: source select and divider
  // ----------------------------------------------------------------
  logic       half_reg;
  logic [7:0] osc_cnt_reg;
  logic [2:0] div_cnt_reg;
  logic       osc_tick, src_raw;

  // The internal oscillator ignores sleep so conversions go on in wait
  assign osc_tick = src_sel == sarc_pkg::SRC_ASYNC && osc_cnt_reg == 8'(ASYNC_OSC_DIV - 1);

  always_comb begin
    case (src_sel)
      sarc_pkg::SRC_BUS:      src_raw = !sleep_mode_in;
      sarc_pkg::SRC_BUS_HALF: src_raw = !sleep_mode_in && half_reg;
      sarc_pkg::SRC_ALT:      src_raw = !sleep_mode_in && alt_rise;
      default:                src_raw = osc_tick;
    endcase
  end

  // Divider limit as 2**div - 1
  wire [2:0] div_lim   = 3'((4'h1 << div_sel) - 4'h1);
  wire       converter_clock_tick = src_raw && div_cnt_reg == div_lim;

  // A config write restarts the divider so the new ratio applies cleanly
  always_ff @(posedge clk_sys) begin
    if (!rstn || wr_cfg) begin
      half_reg    <= 1'b0;
      osc_cnt_reg <= 8'h00;
      div_cnt_reg <= 3'h0;
    end else begin
      half_reg    <= !half_reg;
      osc_cnt_reg <= (src_sel != sarc_pkg::SRC_ASYNC || osc_tick) ? 8'h00 : osc_cnt_reg + 8'h01;
      if (src_raw) div_cnt_reg <= converter_clock_tick ? 3'h0 : div_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  wire       idle      = state_reg == ST_IDLE;
  wire       mode8     = mode_sel == sarc_pkg::MODE_8BIT;
  wire [3:0] last_bit  = mode8 ? 4'h3 : 4'h0;
  wire       sw_start  = wr_ctl1 && !wr_ch_off && !hwt_en;
  wire       hw_start  = hwt_en && trig_rise && idle && chan_sel != sarc_pkg::CH_OFF;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    if (hw_start) state_next = ST_SAMPLE;
      ST_SAMPLE:  if (converter_clock_tick && samp_cnt_reg == 5'(SAMPLE_TICKS - 1)) state_next = ST_CONVERT;
      ST_CONVERT: if (converter_clock_tick && bit_idx_reg == last_bit) state_next = ST_DONE;
      ST_DONE:    state_next = cont_en ? ST_SAMPLE : ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
    // Register writes override: abort, restart or shut down
    if (mode_wr) state_next = ST_IDLE;
    if (wr_ctl1) state_next = sw_start ? ST_SAMPLE : ST_IDLE;
  end

  // Raw result and rounding, saturating at full scale
  wire [8:0]  raw9   = sar_reg[11:3];
  wire [12:0] sum10  = {1'b0, sar_reg} + 13'h0002;
  wire [9:0]  sum8   = {1'b0, raw9} + 10'h001;
  wire [9:0]  rnd10  = sum10[12] ? 10'h3FF : sum10[11:2];
  wire [7:0]  rnd8   = sum8[9] ? 8'hFF : sum8[8:1];
  logic [15:0] res16;
  always_comb begin
    case (mode_sel)
      sarc_pkg::MODE_8BIT:  res16 = {8'h00, rnd8};
      sarc_pkg::MODE_10BIT: res16 = {6'h00, rnd10};
      default:              res16 = {4'h0, sar_reg};  // Reserved code acts as 12-bit
    endcase
  end

  // Compare stores result minus compare value and only completes on a hit
  wire [15:0] cmp16  = {cvh_reg, cvl_reg};
  wire [15:0] diff16 = res16 - cmp16;
  wire        cmp_ok = !cmp_en || (cmp_gt ? res16 >= cmp16 : res16 < cmp16);
  wire [15:0] store  = cmp_en ? diff16 : res16;
  wire        done   = state_reg == ST_DONE && cmp_ok;

  // SAR step: keep the trial bit if the comparator says input is above
  logic [11:0] sar_step;
  always_comb begin
    sar_step = sar_reg;
    if (!comparator_in) sar_step[bit_idx_reg] = 1'b0;
    if (bit_idx_reg != last_bit) sar_step[bit_idx_reg - 4'h1] = 1'b1;
  end

  // Next trial code for the DAC output, set under the same conditions as the SAR register, so the
  // comparator always judges the code that sar_reg holds at a tick
  logic [11:0] sar_next;
  always_comb begin
    sar_next = sar_reg;
    if (state_next == ST_SAMPLE && state_reg != ST_SAMPLE) sar_next = 12'h800;
    else if (state_reg == ST_CONVERT && converter_clock_tick) sar_next = sar_step;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      sar_reg      <= 12'h000;
      bit_idx_reg  <= 4'h0;
      samp_cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (state_next == ST_SAMPLE && state_reg != ST_SAMPLE) begin
        sar_reg      <= 12'h800;
        bit_idx_reg  <= 4'hB;
        samp_cnt_reg <= 5'h00;
      end else if (state_reg == ST_SAMPLE && converter_clock_tick) begin
        samp_cnt_reg <= samp_cnt_reg + 5'h01;
      end else if (state_reg == ST_CONVERT && converter_clock_tick) begin
        sar_reg     <= sar_step;
        bit_idx_reg <= bit_idx_reg - 4'h1;
      end
    end
  end

  // Result registers, completion flag; a new completion beats a clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      res_high_reg <= 8'h00;
      res_low_reg  <= 8'h00;
      conversion_complete_flag_reg     <= 1'b0;
      irq_out      <= 1'b0;
    end else begin
      if (done) begin
        res_high_reg <= store[15:8];
        res_low_reg  <= store[7:0];
      end
      if (done) conversion_complete_flag_reg <= 1'b1;
      else if (wr_ctl1 || rd_low) conversion_complete_flag_reg <= 1'b0;
      irq_out <= conversion_complete_flag_reg && completion_interrupt_enable;
    end
  end

  // Analogue-facing outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dac_code_out             <= 12'h000;
      channel_out              <= sarc_pkg::CH_OFF;
      converter_active_out     <= 1'b0;
      converter_clock_tick_out <= 1'b0;
      async_osc_on_out         <= 1'b0;
    end else begin
      dac_code_out             <= sar_next;
      channel_out              <= chan_sel;
      converter_active_out     <= !idle && chan_sel != sarc_pkg::CH_OFF;
      converter_clock_tick_out <= converter_clock_tick;
      async_osc_on_out         <= src_sel == sarc_pkg::SRC_ASYNC;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] gap_cnt_reg;
  logic       gap_ok_reg;
  // Cycles since the last converter tick, void after config or sleep change
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gap_cnt_reg <= 5'h00;
      gap_ok_reg  <= 1'b0;
    end else begin
      gap_cnt_reg <= converter_clock_tick ? 5'h01 : (gap_cnt_reg == 5'h1F ? gap_cnt_reg : gap_cnt_reg + 5'h01);
      gap_ok_reg  <= (converter_clock_tick || gap_ok_reg) && !wr_cfg && !sleep_mode_in;
    end
  end

  sequence s_mid_write;
    wr_mid ##1 (!wr_mid)[*2];
  endsequence

  a_mid_pin_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_mid_write |-> pin_hiz_out[7:0] == $past(reg_wdata, 2))
    else $error("mid pin disable not applied");
  a_high_pin_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_high ##1 !wr_high |=> pin_input_off_out[15:8] == $past(reg_wdata, 2))
    else $error("high pin disable not applied");
  a_disabled_reads_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (port_read_out & $past(dis_vec)) == 16'h0000)
    else $error("disabled pin reads nonzero");
  a_channel_off_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctl1 && wr_ch_off |=> idle ##1 !converter_active_out)
    else $error("converter left running with channel off");
  a_flag_raises_irq: assert property (@(posedge clk_sys) disable iff (!rstn)
    done && completion_interrupt_enable && !wr_ctl1 |=> conversion_complete_flag_reg ##1 irq_out)
    else $error("completion flag or interrupt missing");
  a_source_reset: assert property (@(posedge clk_sys)
    $rose(rstn) |-> src_sel == sarc_pkg::SRC_BUS && div_sel == 2'h0)
    else $error("clock source not bus after reset");
  a_div_sixteen: assert property (@(posedge clk_sys) disable iff (!rstn)
    converter_clock_tick && gap_ok_reg && src_sel == sarc_pkg::SRC_BUS_HALF && div_sel == 2'h3 |-> gap_cnt_reg == 5'h10)
    else $error("halved bus by eight is not sixteen");
  a_trigger_starts: assert property (@(posedge clk_sys) disable iff (!rstn)
    hw_start && !reg_wr |=> state_reg == ST_SAMPLE)
    else $error("trigger edge did not start conversion");
  a_busy_trigger_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == ST_CONVERT && trig_rise && !reg_wr |=> state_reg inside {ST_CONVERT, ST_DONE})
    else $error("trigger restarted a running conversion");
endmodule
`default_nettype wire

// [test/sarc_analog_model.sv]
/*
  Analogue partner of the converter: the channel voltage as a code and an
  ideal comparator. Assumes the trial code holds between converter ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module sarc_analog_model (
  input  wire logic [11:0] vin_code,
  input  wire logic [11:0] dac_code_out,
  output var  logic        comparator_in
);
  // Comparator is high while the input sits at or above the trial level
  always_comb comparator_in = (vin_code >= dac_code_out);
endmodule
`default_nettype wire

// [test/tb.sv]
/*
  Self-checking bench for the converter control block.
  Assumes the analogue model answers the trial code in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] cfg; logic [11:0] vin; logic [15:0] res; logic [4:0] per;} sarc_row_type;
  logic        clk_sys, rstn, reg_wr, reg_rd, trig, alt_clk, cmp, act, tick, osc, irq;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d, hi;
  logic [11:0] vin, dac;
  logic [15:0] lvl, hiz, puoff, inoff, prd;
  logic [4:0]  chan;
  int          n_mismatch, tests_run, cyc, alt_cnt, p;
  // Mode, divider and source rows: config, input, result, tick period
  sarc_row_type rows [7] = '{'{8'h04, 12'hA5C, 16'h0A5C, 5'd1}, '{8'h28, 12'h3FE, 16'h0100, 5'd2},
    '{8'h40, 12'h7F4, 16'h007F, 5'd4}, '{8'h6C, 12'h123, 16'h0123, 5'd8}, '{8'h65, 12'h800, 16'h0800, 5'd16},
    '{8'h06, 12'h0FF, 16'h00FF, 5'd6}, '{8'h07, 12'h456, 16'h0456, 5'(sarc_pkg::ASYNC_OSC_DIV)}};
  sarc_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hardware_trigger_input(trig), .alternate_clock(alt_clk),
    .sleep_mode_in(1'b0), .comparator_in(cmp), .pin_level_in(lvl), .dac_code_out(dac), .channel_out(chan),
    .converter_active_out(act), .converter_clock_tick_out(tick), .async_osc_on_out(osc), .pin_hiz_out(hiz),
    .pin_pullup_off_out(puoff), .pin_input_off_out(inoff), .port_read_out(prd), .irq_out(irq));
  sarc_analog_model model (.vin_code(vin), .dac_code_out(dac), .comparator_in(cmp));
  // ----------------------------------------------------------------
  // Clocks, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Alternate clock rises every six system cycles, unrelated to conversions
  always @(posedge clk_sys) begin
    alt_cnt <= (alt_cnt == 2) ? 0 : alt_cnt + 1;
    if (alt_cnt == 2) alt_clk <= ~alt_clk;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Polls the completion flag; reading status one leaves it set
  task automatic wait_done();
    d = 8'h00;
    for (int i = 0; i < 400 && d[sarc_pkg::POS_CONVERSION_COMPLETE_FLAG] !== 1'b1; i++) rd(sarc_pkg::OFS_STATUS_CONTROL_ONE, d);
    chk(16'(d[sarc_pkg::POS_CONVERSION_COMPLETE_FLAG]), 16'h0001);
  endtask
  task automatic tick_period(output int n);
    n = 0;
    for (int i = 0; i < 100 && tick !== 1'b1; i++) @(posedge clk_sys) #1;
    do begin
      @(posedge clk_sys) #1;
      n++;
    end while (tick !== 1'b1 && n < 100);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, trig, alt_clk, reg_addr, reg_wdata} = '0;
    {n_mismatch, tests_run, cyc, alt_cnt} = '0;
    vin = 12'h000;
    lvl = 16'hFFFF;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(sarc_pkg::OFS_STATUS_CONTROL_ONE, d);
    chk(16'(d), 16'h001F);
    chk(16'(act), 16'h0000);
    rd(sarc_pkg::OFS_CONFIG, d);
    chk(16'(d), 16'h0000);
    rd(4'hF, d);
    chk(16'(d), 16'h0000);
    foreach (rows[k]) begin
      vin = rows[k].vin;
      wr(sarc_pkg::OFS_CONFIG, rows[k].cfg);
      wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h00);
      tick_period(p);
      chk(16'(p), 16'(rows[k].per));
      chk(16'(osc), 16'(rows[k].cfg[1:0] == 2'h3));
      wait_done();
      rd(sarc_pkg::OFS_RESULT_HIGH, hi);
      rd(sarc_pkg::OFS_RESULT_LOW, d);
      chk({hi, d}, rows[k].res);
      chk(16'(act), 16'h0000);
    end
    // Pin disables on the mid and high groups, all pins driven high
    wr(sarc_pkg::OFS_ANALOG_PIN_DISABLE_MID, 8'hA5);
    wr(sarc_pkg::OFS_ANALOG_PIN_DISABLE_HIGH, 8'h3C);
    repeat (4) @(posedge clk_sys);
    #1 chk(hiz, 16'h3CA5);
    chk(puoff, 16'h3CA5);
    chk(inoff, 16'h3CA5);
    chk(prd, 16'hC35A);
    rd(sarc_pkg::OFS_ANALOG_PIN_DISABLE_MID, d);
    chk(16'(d), 16'h00A5);
    // Interrupt follows the flag, then a channel of all ones aborts
    wr(sarc_pkg::OFS_CONFIG, 8'h04);
    wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h40);
    wait_done();
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(irq), 16'h0001);
    wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h00);
    wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h1F);
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(act), 16'h0000);
    // Compare enabled, greater-or-equal: result is input minus compare value
    vin = 12'h3FF;
    wr(sarc_pkg::OFS_STATUS_CONTROL_TWO, 8'h30);
    wr(sarc_pkg::OFS_COMPARE_HIGH, 8'h02);
    wr(sarc_pkg::OFS_COMPARE_LOW, 8'h00);
    wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h00);
    wait_done();
    rd(sarc_pkg::OFS_RESULT_HIGH, hi);
    rd(sarc_pkg::OFS_RESULT_LOW, d);
    chk({hi, d}, 16'h01FF);
    // Hardware trigger: a status one write alone must not start, the edge does
    vin = 12'h5A5;
    wr(sarc_pkg::OFS_STATUS_CONTROL_TWO, 8'h40);
    wr(sarc_pkg::OFS_STATUS_CONTROL_ONE, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(act), 16'h0000);
    @(posedge clk_sys);
    trig <= 1'b1;
    wait_done();
    rd(sarc_pkg::OFS_RESULT_HIGH, hi);
    rd(sarc_pkg::OFS_RESULT_LOW, d);
    chk({hi, d}, 16'h05A5);
    conclude();
  end
endmodule
`default_nettype wire
